// ### dv/drc_door_model.sv
// Door drive and safety contact model for the relay control bench.
// Assumes motor levels from the block; the door moves one step per clock.
`timescale 1ns/100ps
module drc_door_model
#(
   parameter int TOP = 40
)
(
   input wire logic clk_i,       // Clock
   input wire logic rst_n_i,     // Reset, active low
   input wire logic up_i,        // Motor up
   input wire logic dn_i,        // Motor down
   input wire logic trip_i,      // Edge device hit
   output logic at_open_o,       // Upper limit switch
   output logic at_closed_o,     // Lower limit switch
   output logic [1:0] safe_o     // Safety contacts
);
   int pos;
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pos <= 0;
      end
      else if (up_i && pos < TOP)
      begin
         pos <= pos + 1;
      end
      else if (dn_i && pos > 0)
      begin
         pos <= pos - 1;
      end
   end
   assign at_open_o = (pos == TOP);
   assign at_closed_o = (pos == 0);
   assign safe_o = {2{~trip_i}};
endmodule : drc_door_model

// ### dv/tb_top.sv
// Self-checking bench for the door relay control block.
// Assumes the door model beside it and short blink and test counts.
`timescale 1ns/100ps
module tb_top;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pready, perr, e;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic up = 0, dn = 0, stp = 0, dflt = 0, chain = 0, smk = 0, spos = 0, trip = 0;
   logic at_o, at_c, mu, md, irq;
   logic [1:0] safe, test;
   logic [2:0] radio = '0;
   logic [8:0] relay;
   int bad_count = 0, tests_run = 0, cyc = 0;
   drc_top #(.HALF_CYC(8), .TEST_CYC(5)) u_drc_top (.MCLK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(perr), .CMD_UP_I(up), .CMD_DN_I(dn), .STOP_I(stp), .AT_OPEN_I(at_o),
      .AT_CLOSED_I(at_c), .SAFE_I(safe), .DRIVE_FAULT_I(dflt), .CHAIN_OPEN_I(chain), .RADIO_I(radio),
      .SMOKE_I(smk), .SMOKE_POS_I(spos), .MOTOR_UP_O(mu), .MOTOR_DN_O(md), .TEST_O(test),
      .RELAY_O(relay), .IRQ_O(irq));
   drc_door_model u_drc_door_model (.clk_i(clk), .rst_n_i(rst_n), .up_i(mu), .dn_i(md), .trip_i(trip),
      .at_open_o(at_o), .at_closed_o(at_c), .safe_o(safe));
   initial
   begin
      forever #10 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      q = prdata;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      // One idle cycle keeps back-to-back calls from reassigning psel in one step
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk("reg", q, exp);
   endtask : rd
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         bad_count++;
         wrap_up();
      end
   end
   initial
   begin
      wt(4);
      rst_n <= 1'b1;
      wt(1);
      rd(12'h000, 32'h31);
      rd(12'h008, 32'h30);
      rd(12'h020, 32'h231);
      rd(12'h018, 32'h253653);
      rd(12'h044, 32'h0);
      chk("slverr", e, 1'b1);
      chk("relay", relay, 9'h0);
      $display("test reset done");
      wr(12'h020, 32'h212);
      wr(12'h024, 32'h222);
      wr(12'h028, 32'h112);
      up <= 1'b1;
      wt(3);
      chk("motor", mu, 1'b1);
      chk("relay", relay[2:0], 3'h5);
      wt(8);
      chk("blink", relay[2:0], 3'h1);
      wt(8);
      chk("blink", relay[2:0], 3'h5);
      up <= 1'b0;
      wt(3);
      chk("relay", relay[2:0], 3'h0);
      $display("test movement done");
      wr(12'h008, 32'h21);
      dn <= 1'b1;
      wt(4);
      chk("motor", md, 1'b0);
      chk("relay", relay[1], 1'b1);
      wt(16);
      chk("motor", md, 1'b1);
      wt(40);
      dn <= 1'b0;
      $display("test prerun done");
      wr(12'h020, 32'h006);
      wr(12'h024, 32'h025);
      wr(12'h028, 32'h023);
      wr(12'h014, 32'h1);
      radio <= 3'h2;
      stp <= 1'b1;
      wt(3);
      chk("relay", relay[2:0], 3'h6);
      stp <= 1'b0;
      radio <= 3'h0;
      dflt <= 1'b1;
      wt(3);
      chk("relay", relay[2:0], 3'h5);
      chk("irq", irq, 1'b1);
      dflt <= 1'b0;
      chain <= 1'b1;
      wt(3);
      chk("relay", relay[0], 1'b1);
      chain <= 1'b0;
      wr(12'h010, 32'h1);
      rd(12'h010, 32'h0);
      chk("irq", irq, 1'b0);
      $display("test fault done");
      wr(12'h020, 32'h008);
      smk <= 1'b1;
      wt(3);
      chk("smoke", relay[0], 1'b0);
      spos <= 1'b1;
      wt(3);
      chk("smoke", relay[0], 1'b1);
      smk <= 1'b0;
      spos <= 1'b0;
      $display("test smoke done");
      wr(12'h004, 32'h065);
      wt(2);
      chk("test", test, 2'h2);
      wr(12'h004, 32'h165);
      wt(2);
      chk("test", test, 2'h1);
      wt(8);
      chk("test", test, 2'h2);
      $display("test lines done");
      // Automatic mode: a one-cycle command latches travel both ways
      wr(12'h000, 32'h032);
      wr(12'h020, 32'h232);
      wr(12'h024, 32'h006);
      up <= 1'b1;
      wt(1);
      up <= 1'b0;
      wt(3);
      chk("motor", mu, 1'b1);
      chk("relay", relay[2:0], 3'h1);
      wt(45);
      chk("motor", mu, 1'b0);
      rd(12'h00c, 32'h600);
      dn <= 1'b1;
      wt(1);
      dn <= 1'b0;
      wt(20);
      chk("motor", md, 1'b1);
      chk("relay", relay[2:0], 3'h1);
      trip <= 1'b1;
      wt(3);
      chk("motor", md, 1'b0);
      chk("relay", relay[2:0], 3'h0);
      trip <= 1'b0;
      $display("test auto done");
      wr(12'h000, 32'h131);
      wr(12'h020, 32'h002);
      rd(12'h020, 32'h232);
      wr(12'h018, 32'h0);
      rd(12'h018, 32'h253653);
      wr(12'h02c, 32'h006);
      rd(12'h02c, 32'h006);
      $display("test lock done");
      wrap_up();
   end
endmodule : tb_top

// ### hw/drc_pkg.sv
// Constants for the door relay output control block: register map, fields, codes, timing.
// Assumes one 50 MHz clock and an APB master with 32-bit data.
package drc_pkg;
   // Register byte offsets, relay register word index range and relay count
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SAFETY = 8'h04;
   localparam logic [7:0] OFS_PRERUN = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_INMAP = 8'h18;
   localparam logic [5:0] RELAY_IDX0 = 6'h08;
   localparam logic [5:0] RELAY_IDXN = 6'h10;
   localparam int NUM_RELAY = 9;
   // Field positions
   localparam int CTRL_CNT_LSB = 4;
   localparam int CTRL_SPECIAL = 8;
   localparam int SAFE_TM2_LSB = 4;
   localparam int SAFE_TEST_GO = 8;
   localparam int PRE_DIR_LSB = 4;
   localparam int RCFG_SEL_LSB = 4;
   localparam int RCFG_BEH_LSB = 8;
   localparam int LOCKED_RELAYS = 3;
   // Reset values
   localparam logic [8:0] CTRL_RST = 9'h031;
   localparam logic [6:0] SAFETY_RST = 7'h11;
   localparam logic [5:0] PRERUN_RST = 6'h30;
   localparam logic [23:0] INMAP_RST = 24'h253653;
   localparam logic [9:0] RCFG_RST = 10'h231;
   localparam logic [3:0] RELAY_CNT_MIN = 4'h3;
   localparam logic [3:0] RELAY_CNT_MAX = 4'h9;
   // Relay function, selection and behaviour codes; operating mode and test line codes
   localparam logic [3:0] FN_OFF = 4'h1;
   localparam logic [3:0] FN_MOVE = 4'h2;
   localparam logic [3:0] FN_ENDPOS = 4'h3;
   localparam logic [3:0] FN_LOCK = 4'h4;
   localparam logic [3:0] FN_RADIO = 4'h5;
   localparam logic [3:0] FN_FAULT = 4'h6;
   localparam logic [3:0] FN_BRAKE = 4'h7;
   localparam logic [3:0] FN_SMOKE = 4'h8;
   localparam logic [1:0] SEL_UP = 2'h1;
   localparam logic [1:0] SEL_DN = 2'h2;
   localparam logic [1:0] SEL_BOTH = 2'h3;
   localparam logic [1:0] BEH_BLINK = 2'h1;
   localparam logic [1:0] BEH_STEADY = 2'h2;
   localparam logic [1:0] MODE_HOLD = 2'h1;
   localparam logic [1:0] MODE_AUTO = 2'h2;
   localparam logic [1:0] MODE_SEMI = 2'h3;
   localparam logic [2:0] TEST_PLUS = 3'h5;
   localparam logic [2:0] TEST_MINUS = 3'h6;
   // Timing
   localparam int CLK_HZ = 50_000_000;
   localparam int BLINK_HALF_MS = 500;
   localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
   localparam int TEST_PULSE_MS = 10;
   localparam int TEST_CYC = CLK_HZ / 1000 * TEST_PULSE_MS;
endpackage : drc_pkg

// ### hw/drc_relay_fn.sv
// One relay's function decoder: turns the relay configuration and door state into an on level.
// Assumes all inputs are synchronous levels from the top block.
`timescale 1ns/100ps
module drc_relay_fn
(
   input wire logic [3:0] func_i,    // Function code
   input wire logic [1:0] sel_i,     // Direction, endposition or channel
   input wire logic [1:0] beh_i,     // Blink or steady
   input wire logic mv_up_i,         // Moving or warning upward
   input wire logic mv_dn_i,         // Moving or warning downward
   input wire logic blink_i,         // Blink phase
   input wire logic at_open_i,       // Upper endposition
   input wire logic at_closed_i,     // Lower endposition
   input wire logic [2:0] radio_i,   // Radio channels
   input wire logic fault_i,         // Door blocked
   input wire logic run_i,           // Motor running
   input wire logic smoke_i,         // Smoke position reached
   output wire logic on_o            // Relay energised
);
   wire logic mv_hit;
   wire logic mv_on;
   wire logic end_on;
   wire logic radio_on;
   assign mv_hit = (sel_i == drc_pkg::SEL_UP && mv_up_i) || (sel_i == drc_pkg::SEL_DN && mv_dn_i)
      || (sel_i == drc_pkg::SEL_BOTH && (mv_up_i || mv_dn_i));
   assign mv_on = mv_hit && (beh_i == drc_pkg::BEH_BLINK ? blink_i : 1'b1);
   assign end_on = (sel_i == drc_pkg::SEL_UP && at_open_i) || (sel_i == drc_pkg::SEL_DN && at_closed_i)
      || (sel_i == drc_pkg::SEL_BOTH && (at_open_i || at_closed_i));
   assign radio_on = sel_i != 2'h0 && radio_i[sel_i - 2'h1];
   assign on_o = (func_i == drc_pkg::FN_MOVE && mv_on) || (func_i == drc_pkg::FN_ENDPOS && end_on)
      || (func_i == drc_pkg::FN_RADIO && radio_on) || (func_i == drc_pkg::FN_FAULT && fault_i)
      || ((func_i == drc_pkg::FN_LOCK || func_i == drc_pkg::FN_BRAKE) && run_i)
      || (func_i == drc_pkg::FN_SMOKE && smoke_i);
endmodule : drc_relay_fn

// ### hw/drc_top.sv
// Door relay output control: APB registers, motion sequencer with pre-run warning,
// safety test line drive, smoke position tracking and nine relay outputs.
// Assumes one 50 MHz clock; all door inputs synchronous to it.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module drc_top
#(
   parameter int HALF_CYC = drc_pkg::BLINK_HALF_CYC,
   parameter int TEST_CYC = drc_pkg::TEST_CYC
)
(
   input wire logic MCLK_I,            // System clock
   input wire logic ARST_N_I,          // Async reset, active low
   input wire logic PSEL_I,            // APB select
   input wire logic PENABLE_I,         // APB enable
   input wire logic PWRITE_I,          // APB write
   input wire logic [11:0] PADDR_I,    // APB byte address
   input wire logic [31:0] PWDATA_I,   // APB write data
   output logic [31:0] PRDATA_O,       // APB read data
   output logic PREADY_O,              // APB ready
   output logic PSLVERR_O,             // APB error
   input wire logic CMD_UP_I,          // Up command level
   input wire logic CMD_DN_I,          // Down command level
   input wire logic STOP_I,            // Stop key
   input wire logic AT_OPEN_I,         // Upper endposition
   input wire logic AT_CLOSED_I,       // Lower endposition
   input wire logic [1:0] SAFE_I,      // Safety contacts, high when closed
   input wire logic DRIVE_FAULT_I,     // Drive fault
   input wire logic CHAIN_OPEN_I,      // Safety chain open
   input wire logic [2:0] RADIO_I,     // Radio channels
   input wire logic SMOKE_I,           // Smoke alarm trigger
   input wire logic SMOKE_POS_I,       // Door at smoke hold position
   output logic MOTOR_UP_O,            // Motor up
   output logic MOTOR_DN_O,            // Motor down
   output logic [1:0] TEST_O,          // Safety test lines
   output logic [8:0] RELAY_O,         // Relay coils
   output logic IRQ_O                  // Interrupt, active high
);
   typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_PRE = 3'b010, ST_RUN = 3'b100} drc_mv_state_t;

   logic [8:0] ctrl;
   logic [6:0] safety;
   logic [5:0] prerun;
   logic [23:0] inmap;
   logic [9:0] rcfg [drc_pkg::NUM_RELAY];
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   drc_mv_state_t st;
   drc_mv_state_t next_st;
   logic dir_up;
   logic next_dir_up;
   logic [24:0] half_cnt;
   logic blink;
   logic [4:0] pre_left;
   logic [18:0] test_cnt;
   logic test_act;
   logic smoke_d;
   logic smoke_arm;
   logic smoke_hit;
   logic fault_d;

   // Bus decode
   wire logic setup = PSEL_I && !PENABLE_I;
   wire logic access = PSEL_I && PENABLE_I && PREADY_O;
   wire logic [5:0] widx = PADDR_I[7:2];
   wire logic [5:0] roff = widx - drc_pkg::RELAY_IDX0;
   wire logic [3:0] rly_n = roff[3:0];
   wire logic in_page = PADDR_I[11:8] == 4'h0 && PADDR_I[1:0] == 2'h0;
   wire logic is_relay = in_page && widx >= drc_pkg::RELAY_IDX0 && widx <= drc_pkg::RELAY_IDXN;
   wire logic hit_ctrl = in_page && PADDR_I[7:0] == drc_pkg::OFS_CTRL;
   wire logic hit_safety = in_page && PADDR_I[7:0] == drc_pkg::OFS_SAFETY;
   wire logic hit_prerun = in_page && PADDR_I[7:0] == drc_pkg::OFS_PRERUN;
   wire logic hit_status = in_page && PADDR_I[7:0] == drc_pkg::OFS_STATUS;
   wire logic hit_istat = in_page && PADDR_I[7:0] == drc_pkg::OFS_IRQ_STAT;
   wire logic hit_imask = in_page && PADDR_I[7:0] == drc_pkg::OFS_IRQ_MASK;
   wire logic hit_inmap = in_page && PADDR_I[7:0] == drc_pkg::OFS_INMAP;
   wire logic mapped = hit_ctrl || hit_safety || hit_prerun || hit_status || hit_istat || hit_imask
      || hit_inmap || is_relay;
   wire logic wr = access && PWRITE_I && mapped;
   wire logic special = ctrl[drc_pkg::CTRL_SPECIAL];
   wire logic rly_locked = special && rly_n < 4'(drc_pkg::LOCKED_RELAYS);
   wire logic test_go = wr && hit_safety && PWDATA_I[drc_pkg::SAFE_TEST_GO];

   // Configuration fields
   wire logic [1:0] op_mode = ctrl[1:0];
   wire logic [3:0] cnt_raw = ctrl[drc_pkg::CTRL_CNT_LSB +: 4];
   wire logic [3:0] rly_cnt = cnt_raw < drc_pkg::RELAY_CNT_MIN ? drc_pkg::RELAY_CNT_MIN
      : cnt_raw > drc_pkg::RELAY_CNT_MAX ? drc_pkg::RELAY_CNT_MAX : cnt_raw;
   wire logic [2:0] tm1 = safety[2:0];
   wire logic [2:0] tm2 = safety[drc_pkg::SAFE_TM2_LSB +: 3];
   wire logic [3:0] pre_s = prerun[3:0];
   wire logic [1:0] pre_dir = prerun[drc_pkg::PRE_DIR_LSB +: 2];

   // Door conditions; safety contacts read tripped when open
   wire logic [1:0] safe_trip = ~SAFE_I;
   wire logic fault_ind = DRIVE_FAULT_I || CHAIN_OPEN_I;
   wire logic halt = STOP_I || fault_ind;
   wire logic auto_up = op_mode == drc_pkg::MODE_AUTO || op_mode == drc_pkg::MODE_SEMI;
   wire logic auto_dn = op_mode == drc_pkg::MODE_AUTO;
   wire logic start_up = CMD_UP_I && !AT_OPEN_I && !halt;
   wire logic start_dn = CMD_DN_I && !CMD_UP_I && !AT_CLOSED_I && !halt && safe_trip == 2'h0;
   wire logic keep = dir_up ? !AT_OPEN_I && (auto_up || CMD_UP_I)
      : !AT_CLOSED_I && safe_trip == 2'h0 && (auto_dn || CMD_DN_I);
   wire logic pre_up = pre_s != 4'h0 && (pre_dir == drc_pkg::SEL_UP || pre_dir == drc_pkg::SEL_BOTH);
   wire logic pre_dn = pre_s != 4'h0 && (pre_dir == drc_pkg::SEL_DN || pre_dir == drc_pkg::SEL_BOTH);
   wire logic half_tick = half_cnt == 25'(HALF_CYC - 1);
   wire logic moving = st != ST_IDLE;
   wire logic mv_up = moving && dir_up;
   wire logic mv_dn = moving && !dir_up;
   wire logic running = st == ST_RUN;

   always_comb
   begin
      next_st = st;
      next_dir_up = dir_up;
      case (st)
         ST_IDLE:
         begin
            if (start_up || start_dn)
            begin
               next_dir_up = start_up;
               next_st = (start_up ? pre_up : pre_dn) ? ST_PRE : ST_RUN;
            end
         end
         ST_PRE:
         begin
            if (halt || !keep)
               next_st = ST_IDLE;
            else if (half_tick && pre_left == 5'h01)
               next_st = ST_RUN;
         end
         ST_RUN:
         begin
            if (halt || !keep)
               next_st = ST_IDLE;
         end
         default:
            next_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         st <= ST_IDLE;
         dir_up <= 1'b0;
         MOTOR_UP_O <= 1'b0;
         MOTOR_DN_O <= 1'b0;
      end
      else
      begin
         st <= next_st;
         dir_up <= next_dir_up;
         MOTOR_UP_O <= next_st == ST_RUN && next_dir_up;
         MOTOR_DN_O <= next_st == ST_RUN && !next_dir_up;
      end
   end

   // Half-second timebase restarts with each movement so blink opens on an on phase
   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         half_cnt <= 25'h0;
         blink <= 1'b1;
         pre_left <= 5'h0;
      end
      else if (!moving)
      begin
         half_cnt <= 25'h0;
         blink <= 1'b1;
         pre_left <= {pre_s, 1'b0};
      end
      else
      begin
         half_cnt <= half_tick ? 25'h0 : half_cnt + 25'h1;
         if (half_tick)
            blink <= !blink;
         if (half_tick && pre_left != 5'h0)
            pre_left <= pre_left - 5'h1;
      end
   end

   // Safety device test pulse
   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         test_cnt <= 19'h0;
         test_act <= 1'b0;
         TEST_O <= 2'h0;
      end
      else
      begin
         if (test_go)
         begin
            test_cnt <= 19'(TEST_CYC - 1);
            test_act <= 1'b1;
         end
         else if (test_cnt != 19'h0)
            test_cnt <= test_cnt - 19'h1;
         else
            test_act <= 1'b0;
         TEST_O[0] <= tm1 == drc_pkg::TEST_PLUS ? test_act : tm1 == drc_pkg::TEST_MINUS && !test_act;
         TEST_O[1] <= tm2 == drc_pkg::TEST_PLUS ? test_act : tm2 == drc_pkg::TEST_MINUS && !test_act;
      end
   end

   wire logic smoke_rise = SMOKE_I && !smoke_d;
   wire logic test_done = test_act && test_cnt == 19'h0 && !test_go;
   wire logic [2:0] irq_ev = {test_done, smoke_arm && SMOKE_POS_I && !smoke_hit, fault_ind && !fault_d};
   wire logic [2:0] irq_clr = wr && hit_istat ? PWDATA_I[2:0] : 3'h0;

   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         smoke_d <= 1'b0;
         smoke_arm <= 1'b0;
         smoke_hit <= 1'b0;
         fault_d <= 1'b0;
         irq_stat <= 3'h0;
         IRQ_O <= 1'b0;
      end
      else
      begin
         smoke_d <= SMOKE_I;
         smoke_arm <= SMOKE_I && (smoke_arm || smoke_rise);
         smoke_hit <= SMOKE_I && (smoke_hit || (smoke_arm && SMOKE_POS_I));
         fault_d <= fault_ind;
         // Set wins over a same-cycle clear in irq_stat; for IRQ_O the clear wins that cycle
         irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
         IRQ_O <= |((irq_stat | irq_ev) & ~irq_clr & irq_mask);
      end
   end

   // Register writes
   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         ctrl <= drc_pkg::CTRL_RST;
         safety <= drc_pkg::SAFETY_RST;
         prerun <= drc_pkg::PRERUN_RST;
         inmap <= drc_pkg::INMAP_RST;
         irq_mask <= 3'h0;
         for (int i = 0; i < drc_pkg::NUM_RELAY; i++)
            rcfg[i] <= drc_pkg::RCFG_RST;
      end
      else if (wr)
      begin
         if (hit_ctrl)
            ctrl <= PWDATA_I[8:0];
         if (hit_safety)
            safety <= PWDATA_I[6:0];
         if (hit_prerun)
            prerun <= PWDATA_I[5:0];
         if (hit_imask)
            irq_mask <= PWDATA_I[2:0];
         if (hit_inmap && !special)
            inmap <= PWDATA_I[23:0];
         if (is_relay && !rly_locked)
            rcfg[rly_n] <= PWDATA_I[9:0];
      end
   end

   // Read path and APB answer, one wait-free access cycle
   wire logic [31:0] status = {15'h0, smoke_hit, fault_ind, safe_trip, st, dir_up, RELAY_O};
   wire logic [31:0] rd_mux = hit_ctrl ? {23'h0, ctrl} : hit_safety ? {25'h0, safety}
      : hit_prerun ? {26'h0, prerun} : hit_status ? status : hit_istat ? {29'h0, irq_stat}
      : hit_imask ? {29'h0, irq_mask} : hit_inmap ? {8'h0, inmap}
      : is_relay ? {22'h0, rcfg[rly_n]} : 32'h0;

   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= 32'h0;
      end
      else
      begin
         PREADY_O <= setup;
         PSLVERR_O <= setup && !mapped;
         PRDATA_O <= setup && !PWRITE_I ? rd_mux : 32'h0;
      end
   end

   logic [8:0] rly_on;
   genvar gi;
   for (gi = 0; gi < drc_pkg::NUM_RELAY; gi++)
   begin : g_rly
      drc_relay_fn u_fn
      (
         .func_i(rcfg[gi][3:0]),
         .sel_i(rcfg[gi][drc_pkg::RCFG_SEL_LSB +: 2]),
         .beh_i(rcfg[gi][drc_pkg::RCFG_BEH_LSB +: 2]),
         .mv_up_i(mv_up),
         .mv_dn_i(mv_dn),
         .blink_i(blink),
         .at_open_i(AT_OPEN_I),
         .at_closed_i(AT_CLOSED_I),
         .radio_i(RADIO_I),
         .fault_i(fault_ind),
         .run_i(running),
         .smoke_i(smoke_hit),
         .on_o(rly_on[gi])
      );
   end

   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         RELAY_O <= 9'h0;
      else
         for (int i = 0; i < drc_pkg::NUM_RELAY; i++)
            RELAY_O[i] <= rly_on[i] && 4'(i) < rly_cnt;
   end

   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!ARST_N_I);

   property p_off;
      rcfg[0][3:0] == drc_pkg::FN_OFF |=> !RELAY_O[0];
   endproperty
   a_off: assert property (p_off) else $error("off relay energised");
   property p_dir;
      rcfg[0][3:0] == drc_pkg::FN_MOVE && rcfg[0][5:4] == drc_pkg::SEL_UP && mv_dn |=> !RELAY_O[0];
   endproperty
   a_dir: assert property (p_dir) else $error("up-only relay on while moving down");
   property p_blink;
      running && half_tick && $past(running) |=> blink != $past(blink);
   endproperty
   a_blink: assert property (p_blink) else $error("blink phase missed half second");
   property p_steady;
      rcfg[0][3:0] == drc_pkg::FN_MOVE && rcfg[0][5:4] == drc_pkg::SEL_BOTH
         && rcfg[0][9:8] == drc_pkg::BEH_STEADY && moving |=> RELAY_O[0];
   endproperty
   a_steady: assert property (p_steady) else $error("steady relay off during movement");
   property p_pre;
      st != ST_RUN |-> !MOTOR_UP_O && !MOTOR_DN_O;
   endproperty
   a_pre: assert property (p_pre) else $error("motor driven outside run");
   property p_fault;
      rcfg[0][3:0] == drc_pkg::FN_FAULT |=> RELAY_O[0] == $past(fault_ind);
   endproperty
   a_fault: assert property (p_fault) else $error("fault relay mismatch");
   property p_smoke;
      rcfg[0][3:0] == drc_pkg::FN_SMOKE && !smoke_hit |=> !RELAY_O[0];
   endproperty
   a_smoke: assert property (p_smoke) else $error("smoke relay on early");
   property p_test;
      tm1 == drc_pkg::TEST_PLUS && test_act |=> TEST_O[0];
   endproperty
   a_test: assert property (p_test) else $error("test line not driven high");
   property p_lock;
      special && wr && is_relay && rly_n == 4'h0 |=> $stable(rcfg[0]);
   endproperty
   a_lock: assert property (p_lock) else $error("locked relay rewritten");
   property p_cnt;
      rly_cnt == drc_pkg::RELAY_CNT_MIN |=> RELAY_O[8:3] == 6'h0;
   endproperty
   a_cnt: assert property (p_cnt) else $error("unfitted relay driven");
   c_pre: cover property (st == ST_PRE ##1 st == ST_RUN);
   c_smoke: cover property (smoke_arm ##1 smoke_hit);
   c_test: cover property (test_act ##1 !test_act);
endmodule : drc_top
